/* verilog/csie_regs.svh */
`ifndef CSIE_REGS_SVH
`define CSIE_REGS_SVH
// Functional notes
// RULE1: every card interrupt is either a status-change event or a functional request
// RULE2: signalling is parallel PCI, PCI plus parallel IRQ, or PCI plus serialized
// RULE3: all interrupt signalling leaves only through the seven multifunction terminals
// RULE4: memory card: battery-detect transitions set flags 1 and 0, enables 1 and 0
// RULE5: memory card: ready-line transition sets flag 2, masked by enable 2
// RULE6: I/O card: status-change assertion sets flag 0, masked by enable 0
// RULE7: I/O card: irq-request assertion is functional, unmasked, shown in 91h bit 0
// RULE8: CardBus card: irq-line assertion is functional, unmasked, shown in 91h bit 0
// RULE9: CardBus card: status-change assertion sets socket event 0, masked by mask 0
// RULE10: any card-detect transition sets socket events 2 and 1, for every card type
// RULE11: power-up done sets flag 3 for 16-bit cards, socket event 3 for CardBus
// RULE12: memory cards never produce functional interrupts
// RULE13: status-change flags clear on read by default, or on write-one by mode bit
// RULE14: socket event flags clear on write-one; writing zero leaves them alone
// RULE15: request raised while any enabled flag is set, withdrawn when none remain

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSIE_OFS_FLAGS    8'h04
`define CSIE_OFS_ENABLES  8'h05
`define CSIE_OFS_GCTRL    8'h1E
`define CSIE_OFS_ROUTE    8'h8C
`define CSIE_OFS_FUNC     8'h91
`define CSIE_OFS_MODE     8'h92
`define CSIE_OFS_SEVT     8'hC0
`define CSIE_OFS_SMASK    8'hC4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSIE_FLG_BATT1    0
`define CSIE_FLG_BATT2    1
`define CSIE_FLG_IOSTS    0
`define CSIE_FLG_READY    2
`define CSIE_FLG_PWR      3
`define CSIE_SEV_CSTS     0
`define CSIE_SEV_CDA      1
`define CSIE_SEV_CDB      2
`define CSIE_SEV_PWR      3
`define CSIE_FUNC_BIT     0
`define CSIE_GCTRL_CLRMD  2
`define CSIE_MODE_LSB     1
`define CSIE_INTA_TERM    3'h0
`define CSIE_SER_TERM     3'h6

// edge detector line indices
`define CSIE_LN_BATT1     0
`define CSIE_LN_BATT2     1
`define CSIE_LN_READY     2
`define CSIE_LN_CDA       3
`define CSIE_LN_CDB       4

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define CSIE_RST_NIB      4'h0
`define CSIE_RST_BYTE     8'h00
`define CSIE_SER_DIV      8'h04
`endif

/* verilog/csie_pkg.sv */
package csie_pkg;
  typedef enum logic [1:0] {
    CARD_NONE = 2'b00,
    CARD_MEM  = 2'b01,
    CARD_IO   = 2'b10,
    CARD_CB   = 2'b11
  } csie_card_t;

  typedef enum logic [1:0] {
    SIG_PCI     = 2'b00,
    SIG_PCI_IRQ = 2'b01,
    SIG_PCI_SER = 2'b10,
    SIG_RSVD    = 2'b11
  } csie_sig_t;

  typedef enum logic [1:0] {
    SER_START = 2'b00,
    SER_SLOT  = 2'b01,
    SER_STOP  = 2'b10
  } csie_ser_st_t;
endpackage

/* verilog/csie_if.sv */
`timescale 1ns/1ps
interface csie_edge_if;
  logic [4:0] level;
  logic [4:0] change;
  logic [4:0] rise;
  modport src (input level, output change, output rise);
  modport dst (output level, input change, input rise);
endinterface

interface csie_ser_if;
  logic [15:0] irq;
  logic        line_out;
  logic        line_oe;
  modport tx  (input irq, output line_out, output line_oe);
  modport ctl (output irq, input line_out, input line_oe);
endinterface

/* verilog/csie_edge.sv */
`timescale 1ns/1ps
`include "csie_regs.svh"
module csie_edge (
  input wire logic clk_in,
  input wire logic rst_n_in,
  csie_edge_if.src ev
);
  import csie_pkg::*;

  logic [4:0] prev_r;
  logic [4:0] prev_nxt;
  logic [4:0] chg_r;
  logic [4:0] chg_nxt;
  logic [4:0] rise_r;
  logic [4:0] rise_nxt;
  logic       primed_r;
  logic       primed_nxt;

  // ----------------------------------------------------------------
  // per-line edge detection
  // ----------------------------------------------------------------
  // the first cycle after reset only loads the history, so lines that
  // already sit high do not fake an insertion or status change
  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_line
      assign prev_nxt[i] = ev.level[i];
      assign chg_nxt[i]  = primed_r & (ev.level[i] ^ prev_r[i]);
      assign rise_nxt[i] = primed_r & ev.level[i] & ~prev_r[i];
    end
  endgenerate

  assign primed_nxt = 1'b1;
  assign ev.change  = chg_r;
  assign ev.rise    = rise_r;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prev_r   <= 5'h00;
      chg_r    <= 5'h00;
      rise_r   <= 5'h00;
      primed_r <= 1'b0;
    end else begin
      prev_r   <= prev_nxt;
      chg_r    <= chg_nxt;
      rise_r   <= rise_nxt;
      primed_r <= primed_nxt;
    end
  end
endmodule

/* verilog/csie_serial.sv */
`timescale 1ns/1ps
`include "csie_regs.svh"
module csie_serial (
  input wire logic clk_in,
  input wire logic rst_n_in,
  csie_ser_if.tx   sx
);
  import csie_pkg::*;

  logic [7:0]   div_r;
  logic [7:0]   div_nxt;
  logic         tick;
  csie_ser_st_t st_r;
  csie_ser_st_t st_nxt;
  logic [3:0]   slot_r;
  logic [3:0]   slot_nxt;
  logic         out_r;
  logic         out_nxt;
  logic         oe_r;
  logic         oe_nxt;

  // ----------------------------------------------------------------
  // frame sequencer: start slot, sixteen irq slots, stop slot
  // ----------------------------------------------------------------
  // the line is open drain: it is only ever pulled low, never driven high
  always_comb begin
    tick     = (div_r == (`CSIE_SER_DIV - 8'h01));
    div_nxt  = tick ? 8'h00 : div_r + 8'h01;
    st_nxt   = st_r;
    slot_nxt = slot_r;
    out_nxt  = 1'b0;
    oe_nxt   = 1'b0;
    unique case (st_r)
      SER_START: begin
        oe_nxt = 1'b1;
        if (tick) begin
          st_nxt   = SER_SLOT;
          slot_nxt = 4'h0;
        end
      end
      SER_SLOT: begin
        oe_nxt = sx.irq[slot_r];
        if (tick) begin
          if (slot_r == 4'hF) begin
            st_nxt = SER_STOP;
          end else begin
            slot_nxt = slot_r + 4'h1;
          end
        end
      end
      SER_STOP: begin
        if (tick) begin
          st_nxt = SER_START;
        end
      end
      default: begin
        st_nxt = SER_START;
      end
    endcase
  end

  assign sx.line_out = out_r;
  assign sx.line_oe  = oe_r;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_r  <= 8'h00;
      st_r   <= SER_START;
      slot_r <= 4'h0;
      out_r  <= 1'b0;
      oe_r   <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      st_r   <= st_nxt;
      slot_r <= slot_nxt;
      out_r  <= out_nxt;
      oe_r   <= oe_nxt;
    end
  end
endmodule

/* verilog/csie_top.sv */
`timescale 1ns/1ps
`include "csie_regs.svh"
module csie_top (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire csie_pkg::csie_card_t card_type_in,
  input  wire logic                 battery_detect_one_in,
  input  wire logic                 battery_detect_two_in,
  input  wire logic                 card_ready_in,
  input  wire logic                 card_detect_a_in,
  input  wire logic                 card_detect_b_in,
  input  wire logic                 power_cycle_done_in,
  input  wire logic                 reg_rd_in,
  input  wire logic                 reg_wr_in,
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  output logic      [7:0]           reg_rdata_out,
  output logic      [6:0]           multifunction_terminals_out,
  output logic      [6:0]           multifunction_terminals_oe_out
);
  import csie_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] term_sel(input logic [2:0] idx);
    term_sel = 7'h01 << idx;
  endfunction

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic [3:0] en_r;
  logic [3:0] en_nxt;
  logic [3:0] sevt_r;
  logic [3:0] sevt_nxt;
  logic [3:0] smask_r;
  logic [3:0] smask_nxt;
  logic       clr_mode_r;
  logic       clr_mode_nxt;
  csie_sig_t  sig_r;
  csie_sig_t  sig_nxt;
  logic [7:0] route_r;
  logic [7:0] route_nxt;
  logic       func_r;
  logic       func_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [6:0] term_r;
  logic [6:0] term_nxt;
  logic [6:0] toe_r;
  logic [6:0] toe_nxt;

  logic       is_mem;
  logic       is_io;
  logic       is_cb;
  logic [3:0] set_f;
  logic [3:0] clr_f;
  logic [3:0] set_s;
  logic [3:0] clr_s;
  logic       csc_req;
  logic       inta_req;
  logic       wr_flags;
  logic       rd_flags;
  logic       wr_sevt;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  csie_edge_if ev ();
  csie_ser_if  sx ();

  assign ev.level = {card_detect_b_in, card_detect_a_in, card_ready_in,
                     battery_detect_two_in, battery_detect_one_in};

  // only the routed slot of the frame carries the functional request
  assign sx.irq = (sig_r == SIG_PCI_SER && func_r) ? (16'h0001 << route_r[7:4]) : 16'h0000;

  csie_edge u_edge (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ev       (ev)
  );

  csie_serial u_serial (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .sx       (sx)
  );

  // ----------------------------------------------------------------
  // card classification
  // ----------------------------------------------------------------
  always_comb begin
    is_mem   = (card_type_in == CARD_MEM);
    is_io    = (card_type_in == CARD_IO);
    is_cb    = (card_type_in == CARD_CB);
    wr_flags = reg_wr_in & addr_hit(reg_addr_in, `CSIE_OFS_FLAGS);
    rd_flags = reg_rd_in & addr_hit(reg_addr_in, `CSIE_OFS_FLAGS);
    wr_sevt  = reg_wr_in & addr_hit(reg_addr_in, `CSIE_OFS_SEVT);
  end

  // ----------------------------------------------------------------
  // legacy status-change flags
  // ----------------------------------------------------------------
  always_comb begin
    set_f = 4'h0;
    clr_f = 4'h0;
    if (is_mem) begin
      set_f[`CSIE_FLG_BATT1] = ev.change[`CSIE_LN_BATT1]; // RULE4
      set_f[`CSIE_FLG_BATT2] = ev.change[`CSIE_LN_BATT2]; // RULE4
      set_f[`CSIE_FLG_READY] = ev.change[`CSIE_LN_READY]; // RULE5
    end
    if (is_io) begin
      set_f[`CSIE_FLG_IOSTS] = ev.rise[`CSIE_LN_BATT1]; // RULE6
    end
    if (is_mem | is_io) begin
      set_f[`CSIE_FLG_PWR] = power_cycle_done_in; // RULE11
    end
    if (rd_flags && !clr_mode_r) begin
      clr_f = 4'hF; // RULE13
    end
    if (wr_flags && clr_mode_r) begin
      clr_f = reg_wdata_in[3:0]; // RULE13
    end
    // a new event in the clearing cycle survives the clear
    flags_nxt = (flags_r & ~clr_f) | set_f; // RULE1
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flags_r <= `CSIE_RST_NIB;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // socket event flags
  // ----------------------------------------------------------------
  always_comb begin
    set_s = 4'h0;
    clr_s = 4'h0;
    if (is_cb) begin
      set_s[`CSIE_SEV_CSTS] = ev.rise[`CSIE_LN_BATT1]; // RULE9
      set_s[`CSIE_SEV_PWR]  = power_cycle_done_in; // RULE11
    end
    // detect lines are watched whatever card sits in the socket
    set_s[`CSIE_SEV_CDA] = ev.change[`CSIE_LN_CDA]; // RULE10
    set_s[`CSIE_SEV_CDB] = ev.change[`CSIE_LN_CDB]; // RULE10
    if (wr_sevt) begin
      clr_s = reg_wdata_in[3:0]; // RULE14
    end
    sevt_nxt = (sevt_r & ~clr_s) | set_s; // RULE14
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sevt_r <= `CSIE_RST_NIB;
    end else begin
      sevt_r <= sevt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // functional request status
  // ----------------------------------------------------------------
  // functional requests have no enable bit: the card line is mirrored
  // straight into the status bit and onto the terminals
  always_comb begin
    func_nxt = (is_io | is_cb) & card_ready_in; // RULE7 RULE8 RULE12
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      func_r <= 1'b0;
    end else begin
      func_r <= func_nxt;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    en_nxt       = en_r;
    smask_nxt    = smask_r;
    clr_mode_nxt = clr_mode_r;
    sig_nxt      = sig_r;
    route_nxt    = route_r;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `CSIE_OFS_ENABLES: begin
          en_nxt = reg_wdata_in[3:0];
        end
        `CSIE_OFS_SMASK: begin
          smask_nxt = reg_wdata_in[3:0];
        end
        `CSIE_OFS_GCTRL: begin
          clr_mode_nxt = reg_wdata_in[`CSIE_GCTRL_CLRMD];
        end
        `CSIE_OFS_MODE: begin
          sig_nxt = csie_sig_t'(reg_wdata_in[`CSIE_MODE_LSB +: 2]); // RULE2
        end
        `CSIE_OFS_ROUTE: begin
          route_nxt = reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      en_r       <= `CSIE_RST_NIB;
      smask_r    <= `CSIE_RST_NIB;
      clr_mode_r <= 1'b0;
      sig_r      <= SIG_PCI;
      route_r    <= `CSIE_RST_BYTE;
    end else begin
      en_r       <= en_nxt;
      smask_r    <= smask_nxt;
      clr_mode_r <= clr_mode_nxt;
      sig_r      <= sig_nxt;
      route_r    <= route_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // read data holds between reads; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `CSIE_OFS_FLAGS:   rdata_nxt = {4'h0, flags_r};
        `CSIE_OFS_ENABLES: rdata_nxt = {4'h0, en_r};
        `CSIE_OFS_SEVT:    rdata_nxt = {4'h0, sevt_r};
        `CSIE_OFS_SMASK:   rdata_nxt = {4'h0, smask_r};
        `CSIE_OFS_GCTRL:   rdata_nxt = {5'h00, clr_mode_r, 2'h0};
        `CSIE_OFS_MODE:    rdata_nxt = {5'h00, sig_r, 1'b0};
        `CSIE_OFS_ROUTE:   rdata_nxt = route_r;
        `CSIE_OFS_FUNC:    rdata_nxt = {7'h00, func_r}; // RULE7 RULE8
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_r <= `CSIE_RST_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ----------------------------------------------------------------
  // terminal routing
  // ----------------------------------------------------------------
  // the status-change request always uses the open-drain PCI line on
  // terminal 0; software must not route the parallel irq onto it
  always_comb begin
    csc_req  = |(flags_r & en_r) | |(sevt_r & smask_r); // RULE15
    inta_req = csc_req;
    term_nxt = 7'h00;
    toe_nxt  = 7'h00;
    unique case (sig_r)
      SIG_PCI, SIG_RSVD: begin
        inta_req = csc_req | func_r;
      end
      SIG_PCI_IRQ: begin
        toe_nxt  = term_sel(route_r[2:0]);
        term_nxt = term_sel(route_r[2:0]) & {7{func_r}};
      end
      SIG_PCI_SER: begin
        toe_nxt  = term_sel(`CSIE_SER_TERM) & {7{sx.line_oe}};
        term_nxt = term_sel(`CSIE_SER_TERM) & {7{sx.line_out}};
      end
    endcase
    toe_nxt = toe_nxt | (term_sel(`CSIE_INTA_TERM) & {7{inta_req}}); // RULE2 RULE3
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      term_r <= 7'h00;
      toe_r  <= 7'h00;
    end else begin
      term_r <= term_nxt;
      toe_r  <= toe_nxt;
    end
  end

  assign multifunction_terminals_out    = term_r; // RULE3
  assign multifunction_terminals_oe_out = toe_r;
endmodule

/* bench/csie_far_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// card lines and host pull-ups
// ----------------------------------------------------------------
module csie_far_model (
  input  wire logic       clk_in,
  input  wire logic [6:0] term_out_in,
  input  wire logic [6:0] term_oe_in,
  output logic      [5:0] card_lines_out,
  output logic      [6:0] pin_level_out
);
  initial card_lines_out = 6'h00;

  // an undriven terminal floats up through the host pull-up
  assign pin_level_out = ~term_oe_in | term_out_in;

  task automatic set_line(input int i, input logic v);
    @(posedge clk_in);
    card_lines_out[i] <= v;
  endtask

  // socket power-up finished: one clock of done
  task automatic pulse_power();
    @(posedge clk_in);
    card_lines_out[5] <= 1'b1;
    @(posedge clk_in);
    card_lines_out[5] <= 1'b0;
  endtask
endmodule

/* bench/csie_top_sva.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module csie_top_sva (
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  input wire csie_pkg::csie_card_t card_type_in,
  input wire logic                 battery_detect_one_in,
  input wire logic                 battery_detect_two_in,
  input wire logic                 card_ready_in,
  input wire logic                 card_detect_a_in,
  input wire logic                 card_detect_b_in,
  input wire logic                 power_cycle_done_in,
  input wire logic                 reg_rd_in,
  input wire logic                 reg_wr_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic [7:0]           reg_wdata_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire logic [6:0]           multifunction_terminals_out,
  input wire logic [6:0]           multifunction_terminals_oe_out
);
  import csie_pkg::*;
  logic [1:0] mode_r, mode_nxt;
  logic [2:0] route_r, route_nxt;
  logic [2:1] mask_r, mask_nxt;
  logic [2:0] settle_r, settle_nxt;
  logic       steady;

  // routing changes ripple through for a few clocks, judge terminals only once settled
  assign steady = (settle_r >= 3'h4);

  always_comb begin
    mode_nxt = mode_r;
    route_nxt = route_r;
    mask_nxt = mask_r;
    settle_nxt = (settle_r == 3'h7) ? settle_r : settle_r + 3'h1;
    if (reg_wr_in && reg_addr_in == 8'h92) mode_nxt = reg_wdata_in[2:1];
    if (reg_wr_in && reg_addr_in == 8'h8C) route_nxt = reg_wdata_in[2:0];
    if (reg_wr_in && reg_addr_in == 8'hC4) mask_nxt = reg_wdata_in[2:1];
    if (reg_wr_in && (reg_addr_in == 8'h92 || reg_addr_in == 8'h8C)) settle_nxt = 3'h0;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_r <= 2'h0;
      route_r <= 3'h0;
      mask_r <= 2'h0;
      settle_r <= 3'h0;
    end else begin
      mode_r <= mode_nxt;
      route_r <= route_nxt;
      mask_r <= mask_nxt;
      settle_r <= settle_nxt;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  mem_no_func_a: assert property (reg_rd_in && reg_addr_in == 8'h91 &&
    card_type_in == CARD_MEM && $past(card_type_in) == CARD_MEM |=> !reg_rdata_out[0])
    else $error("functional bit set for a memory card");
  pci_only_term0_a: assert property (mode_r == SIG_PCI && steady |->
    multifunction_terminals_oe_out[6:1] == 6'h00) else $error("extra terminal driven");
  ser_open_drain_a: assert property (mode_r == SIG_PCI_SER && steady |->
    !multifunction_terminals_out[6] && multifunction_terminals_oe_out[5:1] == 5'h00)
    else $error("serial terminal misdriven");
  detect_a_req_a: assert property (mode_r == SIG_PCI && steady && mask_r[1] &&
    $past(rst_n_in, 3) && $changed(card_detect_a_in) |-> ##3
    (multifunction_terminals_oe_out[0] && !multifunction_terminals_out[0]))
    else $error("detect a gave no request");
  detect_b_req_a: assert property (mode_r == SIG_PCI && steady && mask_r[2] &&
    $past(rst_n_in, 3) && $changed(card_detect_b_in) |-> ##3
    (multifunction_terminals_oe_out[0] && !multifunction_terminals_out[0]))
    else $error("detect b gave no request");
  func_unmasked_a: assert property (mode_r == SIG_PCI && steady &&
    $rose(card_ready_in) && (card_type_in == CARD_IO || card_type_in == CARD_CB) &&
    $stable(card_type_in) |-> ##[1:3]
    (multifunction_terminals_oe_out[0] && !multifunction_terminals_out[0]))
    else $error("functional request not passed");
  irq_route_drive_a: assert property (mode_r == SIG_PCI_IRQ && steady |->
    multifunction_terminals_oe_out[route_r]) else $error("routed terminal not driven");
  mem_irq_quiet_a: assert property (mode_r == SIG_PCI_IRQ && steady &&
    card_type_in == CARD_MEM && $past(card_type_in) == CARD_MEM &&
    $past(card_type_in, 2) == CARD_MEM |-> !multifunction_terminals_out[route_r])
    else $error("memory card drove a functional level");

  read_flags_c: cover property (reg_rd_in && reg_addr_in == 8'h04 ##1 reg_rdata_out != 8'h00);
  ser_frame_c: cover property (mode_r == SIG_PCI_SER && multifunction_terminals_oe_out[6]);
  irq_high_c: cover property (mode_r == SIG_PCI_IRQ && multifunction_terminals_out[route_r]);
endmodule

bind csie_top csie_top_sva u_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .card_type_in(card_type_in), .battery_detect_one_in(battery_detect_one_in),
  .battery_detect_two_in(battery_detect_two_in), .card_ready_in(card_ready_in),
  .card_detect_a_in(card_detect_a_in), .card_detect_b_in(card_detect_b_in),
  .power_cycle_done_in(power_cycle_done_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .multifunction_terminals_out(multifunction_terminals_out),
  .multifunction_terminals_oe_out(multifunction_terminals_oe_out));

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import csie_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  csie_card_t card_type = CARD_NONE;
  logic       rd = 1'b0;
  logic       wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [6:0] t_out, t_oe, pin;
  logic [5:0] lines;
  logic [7:0] regs [8] = '{8'h04, 8'h05, 8'h1E, 8'h8C, 8'h91, 8'h92, 8'hC0, 8'hC4};
  int         failures = 0;
  int         compares = 0;
  int         cnt;

  always #20 clk_in = ~clk_in;

  csie_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .card_type_in(card_type),
    .battery_detect_one_in(lines[0]), .battery_detect_two_in(lines[1]),
    .card_ready_in(lines[2]), .card_detect_a_in(lines[3]), .card_detect_b_in(lines[4]),
    .power_cycle_done_in(lines[5]), .reg_rd_in(rd), .reg_wr_in(wr), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .multifunction_terminals_out(t_out),
    .multifunction_terminals_oe_out(t_oe));
  csie_far_model far (.clk_in(clk_in), .term_out_in(t_out), .term_oe_in(t_oe),
    .card_lines_out(lines), .pin_level_out(pin));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // a line change reaches the terminals three clocks after it is sampled
  task automatic ev_wait();
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  task automatic drive_line(input int i, input logic v);
    far.set_line(i, v);
    ev_wait();
  endtask

  task automatic set_type(input csie_card_t t);
    @(posedge clk_in);
    card_type <= t;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic count_ser(input logic [7:0] exp);
    cnt = 0;
    repeat (72) begin
      @(posedge clk_in);
      #1 cnt += int'(t_oe[6]);
    end
    check(8'(cnt), exp);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    foreach (regs[i]) rd_chk(regs[i], 8'h00);
    set_type(CARD_MEM);
    drive_line(0, 1'b1);
    drive_line(1, 1'b1);
    drive_line(2, 1'b1);
    check({1'b0, pin}, 8'h7F);
    rd_chk(8'h91, 8'h00);
    rd_chk(8'h04, 8'h07);
    rd_chk(8'h04, 8'h00);
    wr_reg(8'h05, 8'h04);
    rd_chk(8'h05, 8'h04);
    drive_line(2, 1'b0);
    check({1'b0, pin}, 8'h7E);
    rd_chk(8'h04, 8'h04);
    settle();
    check({1'b0, pin}, 8'h7F);
    wr_reg(8'h1E, 8'h04);
    far.pulse_power();
    ev_wait();
    rd_chk(8'h04, 8'h08);
    rd_chk(8'h04, 8'h08);
    wr_reg(8'h04, 8'h00);
    rd_chk(8'h04, 8'h08);
    wr_reg(8'h04, 8'h08);
    rd_chk(8'h04, 8'h00);
    set_type(CARD_IO);
    drive_line(0, 1'b0);
    drive_line(0, 1'b1);
    check({1'b0, pin}, 8'h7F);
    rd_chk(8'h04, 8'h01);
    drive_line(2, 1'b1);
    check({1'b0, pin}, 8'h7E);
    rd_chk(8'h91, 8'h01);
    drive_line(2, 1'b0);
    rd_chk(8'h91, 8'h00);
    wr_reg(8'h04, 8'h01);
    rd_chk(8'h04, 8'h00);
    set_type(CARD_CB);
    drive_line(0, 1'b0);
    drive_line(0, 1'b1);
    far.pulse_power();
    ev_wait();
    check({1'b0, pin}, 8'h7F);
    rd_chk(8'hC0, 8'h09);
    rd_chk(8'h04, 8'h00);
    wr_reg(8'hC4, 8'h06);
    drive_line(3, 1'b1);
    check({1'b0, pin}, 8'h7E);
    drive_line(4, 1'b1);
    rd_chk(8'hC0, 8'h0F);
    rd_chk(8'h33, 8'h00);
    wr_reg(8'hC0, 8'h00);
    rd_chk(8'hC0, 8'h0F);
    wr_reg(8'hC0, 8'h0F);
    rd_chk(8'hC0, 8'h00);
    settle();
    check({1'b0, pin}, 8'h7F);
    drive_line(2, 1'b1);
    rd_chk(8'h91, 8'h01);
    wr_reg(8'h8C, 8'h03);
    wr_reg(8'h92, 8'h02);
    settle();
    check({1'b0, t_oe}, 8'h08);
    check({1'b0, pin}, 8'h7F);
    drive_line(2, 1'b0);
    check({1'b0, pin}, 8'h77);
    set_type(CARD_MEM);
    drive_line(2, 1'b1);
    check({1'b0, pin}, 8'h76);
    wr_reg(8'h04, 8'h04);
    set_type(CARD_CB);
    wr_reg(8'h92, 8'h04);
    wr_reg(8'h8C, 8'h50);
    settle();
    count_ser(8'h08);
    set_type(CARD_MEM);
    settle();
    count_ser(8'h04);
    wr_reg(8'h92, 8'h00);
    settle();
    check({1'b0, t_oe & 7'h7E}, 8'h00);
    final_report();
  end

  initial begin
    #(40 * 4000);
    failures++;
    final_report();
  end
endmodule
